// ==== hw/ptg_pkg.sv ====
`default_nettype none
package ptg_pkg;

   // ----------------------------------------------------------------
   // Divider chain and register port geometry
   // ----------------------------------------------------------------
   localparam int               PTG_STAGES      = 18;
   localparam int               PTG_AW          = 4;
   localparam int               PTG_DW          = 8;
   localparam int               PTG_TAPW        = 5;
   localparam logic [PTG_AW-1:0] PTG_CTRL_OFFSET = 4'h0;

   // ----------------------------------------------------------------
   // Field layout of tick_control
   // ----------------------------------------------------------------
   localparam int PTG_FLAG_BIT = 7;
   localparam int PTG_RATE_MSB = 6;
   localparam int PTG_RATE_LSB = 4;
   localparam int PTG_ACK_BIT  = 3;
   localparam int PTG_IE_BIT   = 2;
   localparam int PTG_RUN_BIT  = 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [2:0]            PTG_RATE_RST  = 3'h0;
   localparam logic                  PTG_IE_RST    = 1'b0;
   localparam logic                  PTG_RUN_RST   = 1'b0;
   localparam logic                  PTG_FLAG_RST  = 1'b0;
   localparam logic [PTG_DW-1:0]     PTG_RDATA_RST = 8'h00;
   localparam logic [PTG_STAGES-1:0] PTG_CNT_RST   = 18'h00000;

   typedef logic [PTG_TAPW-1:0] ptg_tap_t;

   // Operating mode of the chain; Gray coded along off, run, hold.
   typedef enum logic [1:0] {
      PTG_OFF  = 2'b00,
      PTG_RUN  = 2'b01,
      PTG_HOLD = 2'b11
   } ptg_mode_t;

   // Chain stage whose rising edge marks a rollover; ratio is 2 << stage.
   function automatic ptg_tap_t ptg_tap_bit(input logic [2:0] rate);
      case (rate)
         3'h0:    ptg_tap_bit = 5'h11;
         3'h1:    ptg_tap_bit = 5'h10;
         3'h2:    ptg_tap_bit = 5'h0f;
         3'h3:    ptg_tap_bit = 5'h0e;
         3'h4:    ptg_tap_bit = 5'h05;
         3'h5:    ptg_tap_bit = 5'h04;
         3'h6:    ptg_tap_bit = 5'h03;
         default: ptg_tap_bit = 5'h02;
      endcase
   endfunction : ptg_tap_bit

endpackage : ptg_pkg
`default_nettype wire

// ==== hw/ptg_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
module ptg_divider
   import ptg_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   input  wire logic                  clear,
   input  wire logic                  step,
   input  wire ptg_tap_t              tap,
   output var  logic [PTG_STAGES-1:0] count_q,
   output var  logic                  rollover_q
);

   // ----------------------------------------------------------------
   // Binary chain
   // ----------------------------------------------------------------
   logic [PTG_STAGES-1:0] count_d;

   // The sum wraps naturally past the last stage, so ticks keep coming.
   always_comb begin
      count_d = count_q;
      if (clear) begin
         count_d = PTG_CNT_RST;
      end else if (step) begin
         count_d = count_q + 18'h00001;
      end
   end

   // Held at zero while stopped, so a restart always begins clean.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= PTG_CNT_RST;
      end else begin
         count_q <= count_d;
      end
   end

   // A rising edge at the chosen stage: half a period after a clean
   // start, then one full period between every later edge.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rollover_q <= 1'b0;
      end else begin
         rollover_q <= step & ~clear & ~count_q[tap] & count_d[tap];
      end
   end

endmodule : ptg_divider
`default_nettype wire

// ==== hw/ptg_tick_gen.sv ====
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Eighteen-stage binary chain on the oscillator reference, eight selectable taps.
// - Chain held at zero while run enable is clear; counts once set.
// - Rollover at the selected tap sets the tick flag.
// - Interrupt request when tick flag and interrupt enable are both set.
// - First tick after enabling at half period, later ticks at full period.
// - Rate codes 0..7 divide by 262144,131072,65536,32768,64,32,16,8.
// - Acknowledge bit reads zero; writing one clears the flag, zero does nothing.
// - Tick flag readable, not writable; one while a tick is pending.
// - Interrupt enable is read/write and cleared by reset.
// - Run enable is read/write, reset clears it; toggling it restarts from zero.
// - Wait mode keeps counting; control register not accessible.
// - Stop with oscillator kept alive keeps counting to wake periodically.
// - Stop without oscillator freezes the generator; no register access.
module ptg_tick_gen
   import ptg_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   input  wire logic              osc_reference_clock,
   input  wire logic              wait_mode,
   input  wire logic              stop_mode,
   input  wire logic              osc_on_in_halt,
   input  wire logic [PTG_AW-1:0] bus_addr,
   input  wire logic [PTG_DW-1:0] bus_wdata,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   output var  logic [PTG_DW-1:0] bus_rdata_q,
   output var  logic              tick_irq_q
);

   // ----------------------------------------------------------------
   // Oscillator reference sampling
   // ----------------------------------------------------------------
   logic osc_meta_q;
   logic osc_sync_q;
   logic osc_prev_q;
   logic osc_edge;

   // The reference is far slower than the system clock, so its rising
   // edge becomes a one-cycle step enable instead of a second domain.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         osc_meta_q <= 1'b0;
         osc_sync_q <= 1'b0;
         osc_prev_q <= 1'b0;
      end else begin
         osc_meta_q <= osc_reference_clock;
         osc_sync_q <= osc_meta_q;
         osc_prev_q <= osc_sync_q;
      end
   end

   assign osc_edge = osc_sync_q & ~osc_prev_q;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   logic [2:0] tick_rate_select_q;
   logic       tick_irq_enable_q;
   logic       tick_run_enable_q;
   logic       tick_flag_q;
   logic       tick_flag_d;
   logic       bus_open;
   logic       ctrl_sel;
   logic       ctrl_wr;
   logic       ack_wr;

   // The processor is parked in wait and stop, so the port is closed.
   assign bus_open = ~wait_mode & ~stop_mode;
   assign ctrl_sel = bus_open & (bus_addr == PTG_CTRL_OFFSET);
   assign ctrl_wr  = ctrl_sel & bus_wr;
   assign ack_wr   = ctrl_wr & bus_wdata[PTG_ACK_BIT];

   // Rate changes while running are accepted as written; keeping them
   // out of a running chain is up to software.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tick_rate_select_q <= PTG_RATE_RST;
         tick_irq_enable_q  <= PTG_IE_RST;
         tick_run_enable_q  <= PTG_RUN_RST;
      end else if (ctrl_wr) begin
         tick_rate_select_q <= bus_wdata[PTG_RATE_MSB:PTG_RATE_LSB];
         tick_irq_enable_q  <= bus_wdata[PTG_IE_BIT];
         tick_run_enable_q  <= bus_wdata[PTG_RUN_BIT];
      end
   end

   // Read data stand for exactly one cycle; the acknowledge and spare
   // bits always read zero, as does any other address.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata_q <= PTG_RDATA_RST;
      end else if (ctrl_sel & bus_rd) begin
         bus_rdata_q                            <= PTG_RDATA_RST;
         bus_rdata_q[PTG_FLAG_BIT]              <= tick_flag_q;
         bus_rdata_q[PTG_RATE_MSB:PTG_RATE_LSB] <= tick_rate_select_q;
         bus_rdata_q[PTG_IE_BIT]                <= tick_irq_enable_q;
         bus_rdata_q[PTG_RUN_BIT]               <= tick_run_enable_q;
      end else begin
         bus_rdata_q <= PTG_RDATA_RST;
      end
   end

   // ----------------------------------------------------------------
   // Operating mode
   // ----------------------------------------------------------------
   ptg_mode_t mode_q;
   ptg_mode_t mode_d;
   logic      osc_dead;

   // In stop the chain only sees edges if its oscillator is kept alive.
   assign osc_dead = stop_mode & ~osc_on_in_halt;

   always_comb begin
      case (mode_q)
         PTG_OFF:  mode_d = tick_run_enable_q ? PTG_RUN : PTG_OFF;
         PTG_RUN:  mode_d = !tick_run_enable_q ? PTG_OFF :
                            (osc_dead ? PTG_HOLD : PTG_RUN);
         PTG_HOLD: mode_d = !tick_run_enable_q ? PTG_OFF :
                            (osc_dead ? PTG_HOLD : PTG_RUN);
         default:  mode_d = PTG_OFF;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= PTG_OFF;
      end else begin
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------------------------------
   // Divider chain
   // ----------------------------------------------------------------
   logic [PTG_STAGES-1:0] count_q;
   logic                  rollover_q;
   logic                  step;
   ptg_tap_t              tap;

   // Wait mode does not gate the step, so ticks keep flowing there.
   assign step = osc_edge & (mode_q == PTG_RUN);
   assign tap  = ptg_tap_bit(tick_rate_select_q);

   ptg_divider u_divider (
      .clk_sys    (clk_sys),
      .arst_n     (arst_n),
      .clear      (~tick_run_enable_q),
      .step       (step),
      .tap        (tap),
      .count_q    (count_q),
      .rollover_q (rollover_q)
   );

   // ----------------------------------------------------------------
   // Tick flag and request
   // ----------------------------------------------------------------
   // A rollover in the same cycle as an acknowledge wins, so no tick is
   // ever lost to a late acknowledge.
   always_comb begin
      tick_flag_d = tick_flag_q;
      if (rollover_q) begin
         tick_flag_d = 1'b1;
      end else if (ack_wr) begin
         tick_flag_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tick_flag_q <= PTG_FLAG_RST;
      end else begin
         tick_flag_q <= tick_flag_d;
      end
   end

   // Built from next values, so the request equals the AND of the two
   // register bits in every cycle and still leaves a flip-flop.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tick_irq_q <= 1'b0;
      end else begin
         tick_irq_q <= tick_flag_d & (ctrl_wr ? bus_wdata[PTG_IE_BIT]
                                              : tick_irq_enable_q);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [PTG_STAGES:0] steps_q;
   logic [PTG_STAGES:0] ratio;
   logic [PTG_STAGES:0] tap_mask;
   logic                seen_q;

   // Steps since the last rollover, and whether one has been seen.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         steps_q <= 19'h00000;
         seen_q  <= 1'b0;
      end else if (!tick_run_enable_q) begin
         steps_q <= 19'h00000;
         seen_q  <= 1'b0;
      end else begin
         steps_q <= (rollover_q ? 19'h00000 : steps_q) + {18'h00000, step};
         seen_q  <= seen_q | rollover_q;
      end
   end

   assign ratio    = 19'h00002 << tap;
   assign tap_mask = ratio - 19'h00001;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence s_ack_write;
      ack_wr && !rollover_q;
   endsequence

   // The request is built from the next flag value, so it falls in the
   // same cycle as the flag rather than one cycle behind it.
   sequence s_flag_gone;
      !tick_flag_q && !tick_irq_q;
   endsequence

   property p_hold_zero;
      !tick_run_enable_q |=> count_q == PTG_CNT_RST;
   endproperty
   a_hold_zero: assert property (p_hold_zero) else $error("chain not held at zero");

   property p_flag_set;
      rollover_q |=> tick_flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("rollover did not set flag");

   property p_irq_level;
      tick_irq_q == (tick_flag_q && tick_irq_enable_q);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("request not flag and enable");

   property p_first_half;
      rollover_q && !seen_q |-> steps_q == (ratio >> 1);
   endproperty
   a_first_half: assert property (p_first_half) else $error("first tick not at half period");

   property p_full_period;
      rollover_q && seen_q && $stable(tap) |-> steps_q == ratio;
   endproperty
   a_full_period: assert property (p_full_period) else $error("tick period wrong");

   property p_tap_ratio;
      rollover_q |-> (count_q[PTG_STAGES-1:0] & tap_mask[PTG_STAGES-1:0])
                     == (ratio[PTG_STAGES-1:0] >> 1);
   endproperty
   a_tap_ratio: assert property (p_tap_ratio) else $error("rollover at wrong stage");

   property p_ack_clear;
      s_ack_write |=> s_flag_gone;
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear");

   property p_ack_reads_zero;
      !bus_rdata_q[PTG_ACK_BIT];
   endproperty
   a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read one");

   property p_flag_sticky;
      tick_flag_q && !ack_wr |=> tick_flag_q;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped unasked");

   property p_restart;
      $rose(tick_run_enable_q) |-> count_q == PTG_CNT_RST;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not from zero");

   property p_port_closed;
      bus_wr && !bus_open |=> $stable(tick_rate_select_q) && $stable(tick_run_enable_q)
                              && $stable(tick_irq_enable_q);
   endproperty
   a_port_closed: assert property (p_port_closed) else $error("write taken while halted");

   property p_stop_frozen;
      mode_q == PTG_HOLD && tick_run_enable_q |=> $stable(count_q);
   endproperty
   a_stop_frozen: assert property (p_stop_frozen) else $error("chain moved in dead stop");

   property p_wrap;
      step && tick_run_enable_q && (&count_q) |=> count_q == PTG_CNT_RST;
   endproperty
   a_wrap: assert property (p_wrap) else $error("chain did not wrap");

endmodule : ptg_tick_gen
`default_nettype wire

// ==== sim/test_ptg_tick_gen.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_ptg_tick_gen;
   import ptg_pkg::*;

   // ----------------------------------------------------------------
   // Stimulus and observation signals
   // ----------------------------------------------------------------
   logic              clk_sys;
   logic              arst_n;
   logic              osc_ref;
   logic              wait_mode;
   logic              stop_mode;
   logic              osc_halt;
   logic [PTG_AW-1:0] bus_addr;
   logic [PTG_DW-1:0] bus_wdata;
   logic              bus_wr;
   logic              bus_rd;
   logic [PTG_DW-1:0] bus_rdata_q;
   logic              tick_irq_q;
   logic [PTG_DW-1:0] v;
   int                miscompares;
   int                total_checks;
   int                cycles;
   int                ratio;

   ptg_tick_gen i_ptg_tick_gen (
      .clk_sys             (clk_sys),
      .arst_n              (arst_n),
      .osc_reference_clock (osc_ref),
      .wait_mode           (wait_mode),
      .stop_mode           (stop_mode),
      .osc_on_in_halt      (osc_halt),
      .bus_addr            (bus_addr),
      .bus_wdata           (bus_wdata),
      .bus_wr              (bus_wr),
      .bus_rd              (bus_rd),
      .bus_rdata_q         (bus_rdata_q),
      .tick_irq_q          (tick_irq_q)
   );

   // 20 MHz system clock.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Cuts a hang short; the slowest rate tested, code 3, alone needs about 66k cycles.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Comparison and report tasks
   // ----------------------------------------------------------------
   task automatic chk_bit(input string name, input logic exp, input logic got);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_byte

   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   // ----------------------------------------------------------------
   // Register port and oscillator drivers
   // ----------------------------------------------------------------
   // Builds a control byte; the flag position is written as zero since it is read-only.
   function automatic logic [7:0] ctl(input logic [2:0] r, input logic ack, input logic ie,
                                      input logic run);
      return {1'b0, r, ack, ie, run, 1'b0};
   endfunction : ctl

   // One idle edge after the strobe, so back-to-back writes never drive it twice at once.
   task automatic wr(input logic [PTG_AW-1:0] a, input logic [7:0] d);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk_sys);
      bus_wr    <= 1'b0;
      @(posedge clk_sys);
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample just past that edge,
   // then wait for the next edge so that all later stimulus lands on the clock.
   task automatic rd(input logic [PTG_AW-1:0] a, output logic [7:0] d);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk_sys);
      bus_rd   <= 1'b0;
      #1;
      d = bus_rdata_q;
      @(posedge clk_sys);
   endtask : rd

   // Each oscillator period spans four system clocks, wider than the synchroniser needs.
   task automatic pulses(input int n);
      repeat (n) begin
         osc_ref <= 1'b1;
         repeat (2) @(posedge clk_sys);
         osc_ref <= 1'b0;
         repeat (2) @(posedge clk_sys);
      end
      repeat (6) @(posedge clk_sys);
   endtask : pulses

   // The request must stay low one edge short of the count and rise on the edge itself.
   task automatic tick_at(input string name, input int n);
      pulses(n - 1);
      chk_bit({name, " early"}, 1'b0, tick_irq_q);
      pulses(1);
      chk_bit(name, 1'b1, tick_irq_q);
   endtask : tick_at

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {arst_n, osc_ref, wait_mode, stop_mode, osc_halt, bus_wr, bus_rd} = '0;
      bus_addr     = '0;
      bus_wdata    = '0;
      miscompares  = 0;
      total_checks = 0;
      cycles       = 0;
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      rd(4'h0, v);
      chk_byte("ctrl reset", 8'h00, v);
      chk_bit("irq reset", 1'b0, tick_irq_q);
      wr(4'h0, 8'hff);
      rd(4'h0, v);
      chk_byte("ctrl all ones", 8'h76, v);
      wr(4'h0, 8'h08);
      wr(4'h5, 8'hff);
      rd(4'h5, v);
      chk_byte("unmapped read", 8'h00, v);
      rd(4'h0, v);
      chk_byte("ctrl after unmapped write", 8'h00, v);
      for (int r = 0; r < 8; r++) begin
         wr(4'h0, ctl(3'(r), 1'b0, 1'b0, 1'b0));
         rd(4'h0, v);
         chk_byte("rate field", ctl(3'(r), 1'b0, 1'b0, 1'b0), v);
      end
      $display("Test fields finished");
      for (int r = 4; r < 8; r++) begin
         ratio = 64 >> (r - 4);
         wr(4'h0, ctl(3'(r - 1), 1'b0, 1'b1, 1'b0));
         wr(4'h0, ctl(3'(r), 1'b1, 1'b1, 1'b0));
         wr(4'h0, ctl(3'(r), 1'b0, 1'b1, 1'b1));
         tick_at("first tick", ratio / 2);
         rd(4'h0, v);
         chk_byte("flag set", ctl(3'(r), 1'b0, 1'b1, 1'b1) | 8'h80, v);
         wr(4'h0, ctl(3'(r), 1'b0, 1'b1, 1'b1));
         pulses(0);
         chk_bit("ack zero", 1'b1, tick_irq_q);
         wr(4'h0, ctl(3'(r), 1'b1, 1'b1, 1'b1));
         pulses(0);
         chk_bit("ack one", 1'b0, tick_irq_q);
         tick_at("full tick", ratio);
      end
      $display("Test periods finished");
      wr(4'h0, ctl(3'h7, 1'b0, 1'b0, 1'b1));
      pulses(0);
      chk_bit("irq masked", 1'b0, tick_irq_q);
      rd(4'h0, v);
      chk_byte("flag kept", 8'hf2, v);
      wr(4'h0, ctl(3'h7, 1'b0, 1'b1, 1'b1));
      pulses(0);
      chk_bit("irq unmasked", 1'b1, tick_irq_q);
      wait_mode <= 1'b1;
      wr(4'h0, ctl(3'h7, 1'b1, 1'b1, 1'b1));
      rd(4'h0, v);
      chk_byte("wait read", 8'h00, v);
      pulses(0);
      chk_bit("wait ack ignored", 1'b1, tick_irq_q);
      wait_mode <= 1'b0;
      wr(4'h0, ctl(3'h7, 1'b1, 1'b1, 1'b1));
      wait_mode <= 1'b1;
      tick_at("wait tick", 8);
      wait_mode <= 1'b0;
      wr(4'h0, ctl(3'h7, 1'b1, 1'b1, 1'b1));
      stop_mode <= 1'b1;
      osc_halt  <= 1'b1;
      tick_at("stop tick", 8);
      stop_mode <= 1'b0;
      wr(4'h0, ctl(3'h7, 1'b1, 1'b1, 1'b1));
      osc_halt  <= 1'b0;
      stop_mode <= 1'b1;
      pulses(8);
      chk_bit("stop frozen", 1'b0, tick_irq_q);
      rd(4'h0, v);
      chk_byte("stop read", 8'h00, v);
      stop_mode <= 1'b0;
      tick_at("resume tick", 8);
      $display("Test modes finished");
      wr(4'h0, ctl(3'h7, 1'b0, 1'b1, 1'b0));
      wr(4'h0, ctl(3'h3, 1'b1, 1'b1, 1'b0));
      wr(4'h0, ctl(3'h3, 1'b0, 1'b1, 1'b1));
      tick_at("slow first tick", 16384);
      $display("Test slow rate finished");
      end_of_test();
   end

endmodule : test_ptg_tick_gen
`default_nettype wire
